// file: design/mcuiw_core.sv
// interrupt, low-power and wake logic with its register slave
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ns
module mcuiw_core (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst,
   // register bus
   input  wire mcuiw_pkg::mcuiw_ahb_req_type ahb_req,
   output mcuiw_pkg::mcuiw_ahb_rsp_type      ahb_rsp,
   // external active-low request pins: main, aux a, aux b
   input  wire logic [2:0]                  req_pins_n,
   // peripheral events
   input  wire mcuiw_pkg::mcuiw_evt_type     evt,
   // processor core
   input  wire mcuiw_pkg::mcuiw_cpu_in_type  cpu_in,
   output mcuiw_pkg::mcuiw_cpu_out_type      cpu_out
);
   import mcuiw_pkg::*;

   typedef struct packed {
      logic [2:0]        sense_edge;
      logic [1:0]        aux_en;
      logic [1:0]        aux_flag;
      logic              main_latch;
      logic [2:0]        pin_prev;
      logic [2:0]        tmr_en;
      logic [2:0]        tmr_arm;
      logic [2:0]        rtc_en;
      logic [2:0]        rtc_flag;
      logic              stop_osc;
      logic              swi_pend;
      mcuiw_lp_type      lp;
      logic              dp_valid;
      logic              dp_write;
      logic [7:0]        dp_idx;
      mcuiw_ahb_rsp_type rsp;
      mcuiw_cpu_out_type cpu;
   } mcuiw_core_state_type;

   function automatic mcuiw_core_state_type reset_state();
      mcuiw_core_state_type s;
      s               = '0;
      s.pin_prev      = PINS_IDLE;
      s.lp            = LP_RUN;
      s.rsp.hreadyout = 1'b1;
      s.cpu.irq_req   = 1'b1;
      s.cpu.vector    = VEC_RESET;
      s.cpu.mask_set  = 1'b1;
      s.cpu.proc_clk_en = 1'b1;
      s.cpu.osc_en    = 1'b1;
      return s;
   endfunction

   localparam mcuiw_core_state_type CORE_RESET = reset_state();

   mcuiw_core_state_type st_q;
   mcuiw_core_state_type st_d;

   logic [2:0] pin_s;
   logic [2:0] tmr_flags;
   logic [2:0] tmr_clr;
   logic [2:0] trig;
   logic       ap;
   logic       ap_rd;
   logic [7:0] ap_idx;
   logic       dp_wr;
   logic [7:0] wd;
   logic [7:0] rd;
   logic       p_irq;
   logic       p_a;
   logic       p_b;
   logic       p_tmr;
   logic       p_rtc;
   logic       hw_any;
   logic       ack;

   mcuiw_sync #(
      .WIDTH (3)
   ) u_sync (
      .clk       (clk),
      .rst       (rst),
      .pin_async (req_pins_n),
      .pin_sync  (pin_s)
   );

   mcuiw_timer_flags u_tflags (
      .clk      (clk),
      .rst      (rst),
      .flag_set ({evt.capture, evt.compare, evt.wrap}),
      .flag_clr (tmr_clr),
      .flags    (tmr_flags)
   );

   always_comb begin
      st_d = st_q;
      st_d.cpu.stack_push = 1'b0;
      st_d.cpu.mask_set   = 1'b0;

      // pin detection: falling edge always, low level unless edge-only
      st_d.pin_prev = pin_s;
      trig = (st_q.pin_prev & ~pin_s) | (~st_q.sense_edge & ~pin_s);

      // bus phases; zero wait state, every answer OKAY
      ap     = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
      ap_idx = ahb_req.haddr[IDX_MSB:IDX_LSB];
      ap_rd  = ap & ~ahb_req.hwrite;
      dp_wr  = st_q.dp_valid & st_q.dp_write;
      wd     = ahb_req.hwdata[7:0];
      st_d.dp_valid = ap;
      st_d.dp_write = ahb_req.hwrite;
      st_d.dp_idx   = ap_idx;

      // timer clear sequence: status read with flag set, then low byte access (a read only for the counter)
      tmr_clr = '0;
      tmr_clr[TMR_WRAP] = st_q.tmr_arm[TMR_WRAP] & ap_rd & (ap_idx == IDX_CNT_LO);
      tmr_clr[TMR_CMP]  = st_q.tmr_arm[TMR_CMP] & ((ap_rd & (ap_idx == IDX_CMP_LO)) |
                          (dp_wr & (st_q.dp_idx == IDX_CMP_LO)));
      tmr_clr[TMR_CAP]  = st_q.tmr_arm[TMR_CAP] & ((ap_rd & (ap_idx == IDX_CAP_LO)) |
                          (dp_wr & (st_q.dp_idx == IDX_CAP_LO)));
      st_d.tmr_arm = st_q.tmr_arm & ~tmr_clr;
      if (ap_rd && ap_idx == IDX_TSR) begin
         st_d.tmr_arm = st_d.tmr_arm | tmr_flags;
      end

      // register writes in the data phase
      if (dp_wr) begin
         unique case (st_q.dp_idx)
            IDX_TCR: begin
               st_d.tmr_en[TMR_CAP]  = wd[BIT_CAP];
               st_d.tmr_en[TMR_CMP]  = wd[BIT_CMP];
               st_d.tmr_en[TMR_WRAP] = wd[BIT_WRAP];
            end
            IDX_RTC_CTRL: begin
               st_d.rtc_en = {wd[BIT_DAY], wd[BIT_SEC], wd[BIT_ALRM]};
            end
            IDX_RTC_STAT: begin
               st_d.rtc_flag = st_q.rtc_flag & ~{wd[BIT_DAY], wd[BIT_SEC], wd[BIT_ALRM]};
            end
            IDX_PIN_EN: begin
               st_d.aux_en = {wd[BIT_B_HI], wd[BIT_A_HI]};
            end
            IDX_PIN_FLAG: begin
               st_d.aux_flag = st_q.aux_flag & ~{wd[BIT_B_HI], wd[BIT_A_HI]};
            end
            IDX_MISC: begin
               st_d.sense_edge = {wd[BIT_B_HI], wd[BIT_A_HI], wd[BIT_MAIN_SEL]};
            end
            IDX_LP_CTRL: begin
               st_d.stop_osc = wd[BIT_STOPOSC];
            end
            default: begin
            end
         endcase
      end

      // flags set regardless of enables; a set beats a same-cycle clear
      st_d.aux_flag = st_d.aux_flag | trig[PIN_B:PIN_A];
      st_d.rtc_flag = st_d.rtc_flag | {evt.day_roll, evt.second, evt.alarm_equal};
      st_d.swi_pend = st_q.swi_pend | cpu_in.swi_exec;

      // pending sources, each but the main line gated by its own enable
      p_irq  = st_q.main_latch;
      p_a    = st_q.aux_flag[0] & st_q.aux_en[0];
      p_b    = st_q.aux_flag[1] & st_q.aux_en[1];
      p_tmr  = |(tmr_flags & st_q.tmr_en);
      p_rtc  = |(st_q.rtc_flag & st_q.rtc_en);
      hw_any = p_irq | p_a | p_b | p_tmr | p_rtc;

      // request towards the core
      ack = cpu_in.ack & st_q.cpu.irq_req;
      st_d.main_latch = st_q.main_latch;
      if (ack) begin
         st_d.cpu.irq_req    = 1'b0;
         st_d.cpu.mask_set   = 1'b1;
         st_d.cpu.stack_push = (st_q.cpu.vector != VEC_RESET);
         if (st_q.cpu.vector == VEC_IRQ) begin
            st_d.main_latch = 1'b0;
         end
         if (st_q.cpu.vector == VEC_SWI) begin
            st_d.swi_pend = cpu_in.swi_exec;
         end
      end else if (st_q.cpu.irq_req && st_q.cpu.vector == VEC_RESET) begin
         st_d.cpu.irq_req = 1'b1;
      end else if (st_q.lp != LP_RUN) begin
         st_d.cpu.irq_req = 1'b0;
      end else if (st_q.swi_pend) begin
         st_d.cpu.irq_req = 1'b1;
         st_d.cpu.vector  = VEC_SWI;
      end else if (!cpu_in.mask && hw_any) begin
         st_d.cpu.irq_req = 1'b1;
         if (p_irq) begin
            st_d.cpu.vector = VEC_IRQ;
         end else if (p_a) begin
            st_d.cpu.vector = VEC_AUX_A;
         end else if (p_tmr) begin
            st_d.cpu.vector = VEC_TIMER;
         end else if (p_b) begin
            st_d.cpu.vector = VEC_AUX_B;
         end else begin
            st_d.cpu.vector = VEC_RTC;
         end
      end else begin
         st_d.cpu.irq_req = 1'b0;
      end
      st_d.main_latch = st_d.main_latch | trig[PIN_MAIN];

      // low-power sequencing
      unique case (st_q.lp)
         LP_RUN: begin
            if (cpu_in.stop_exec) begin
               st_d.lp = LP_STOP;
            end else if (cpu_in.wait_exec) begin
               st_d.lp = LP_WAIT;
            end
         end
         LP_WAIT: begin
            if (|trig || hw_any || evt.spi_irq) begin
               st_d.lp = LP_RUN;
            end
         end
         LP_STOP: begin
            if (|trig) begin
               st_d.lp = LP_RUN;
            end
         end
         default: begin
            st_d.lp = LP_RUN;
         end
      endcase
      st_d.cpu.proc_clk_en = (st_d.lp == LP_RUN);
      st_d.cpu.osc_en      = !(st_d.lp == LP_STOP && st_d.stop_osc);

      // read data, taken after this cycle's writes
      rd = '0;
      unique case (ap_idx)
         IDX_TCR: begin
            rd[BIT_CAP]  = st_d.tmr_en[TMR_CAP];
            rd[BIT_CMP]  = st_d.tmr_en[TMR_CMP];
            rd[BIT_WRAP] = st_d.tmr_en[TMR_WRAP];
         end
         IDX_TSR: begin
            rd[BIT_CAP]  = tmr_flags[TMR_CAP];
            rd[BIT_CMP]  = tmr_flags[TMR_CMP];
            rd[BIT_WRAP] = tmr_flags[TMR_WRAP];
         end
         IDX_RTC_CTRL: begin
            rd[BIT_DAY:BIT_ALRM] = st_d.rtc_en;
         end
         IDX_RTC_STAT: begin
            rd[BIT_DAY:BIT_ALRM] = st_d.rtc_flag;
         end
         IDX_PIN_EN: begin
            rd[BIT_B_HI:BIT_A_HI] = st_d.aux_en;
         end
         IDX_PIN_FLAG: begin
            rd[BIT_B_HI:BIT_A_HI]   = st_d.aux_flag;
            rd[BIT_B_LVL:BIT_A_LVL] = pin_s[PIN_B:PIN_A];
         end
         IDX_MISC: begin
            rd[BIT_B_HI:BIT_MAIN_SEL] = st_d.sense_edge;
         end
         IDX_LP_CTRL: begin
            rd[BIT_STOPOSC] = st_d.stop_osc;
         end
         default: begin
         end
      endcase
      st_d.rsp.hreadyout = 1'b1;
      st_d.rsp.hresp     = 1'b0;
      st_d.rsp.hrdata    = ap_rd ? {24'h00_0000, rd} : RD_ZERO;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= CORE_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign ahb_rsp = st_q.rsp;
   assign cpu_out = st_q.cpu;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_swi_issued;
      cpu_in.swi_exec && !st_q.cpu.irq_req && st_q.lp == LP_RUN;
   endsequence
   sequence s_swi_vectored;
      ##2 (cpu_out.irq_req && cpu_out.vector == VEC_SWI);
   endsequence

   a_reset_vector_fetch: assert property (
      $past(rst) |-> (cpu_out.irq_req && cpu_out.vector == VEC_RESET && cpu_out.mask_set))
      else $error("reset vector not presented after reset");
   a_swi_ignores_mask: assert property (s_swi_issued |-> s_swi_vectored)
      else $error("software trap not vectored");
   a_mask_blocks_hw: assert property (
      (cpu_out.irq_req && cpu_out.vector != VEC_RESET && cpu_out.vector != VEC_SWI)
      |-> !$past(cpu_in.mask))
      else $error("hardware request passed a set mask");
   a_ack_sets_mask: assert property (
      (ack && st_q.cpu.vector != VEC_RESET) |=> (cpu_out.mask_set && cpu_out.stack_push && !cpu_out.irq_req))
      else $error("recognition did not push state and set mask");
   a_aux_needs_enable: assert property (
      (cpu_out.irq_req && cpu_out.vector == VEC_AUX_B) |-> $past(st_q.aux_en[1] && st_q.aux_flag[1]))
      else $error("aux b request without enable");
   a_aux_flag_w1c: assert property (
      (dp_wr && st_q.dp_idx == IDX_PIN_FLAG && wd[BIT_A_HI] && !trig[PIN_A]) |=> !st_q.aux_flag[0])
      else $error("aux a flag not cleared by writing one");
   a_level_readback: assert property (
      (ap_rd && ap_idx == IDX_PIN_FLAG) |=> ahb_rsp.hrdata[BIT_B_LVL:BIT_A_LVL] == $past(pin_s[PIN_B:PIN_A]))
      else $error("pin levels not reflected");
   a_level_retrigger: assert property (
      (!st_q.sense_edge[PIN_MAIN] && !pin_s[PIN_MAIN]) |=> st_q.main_latch)
      else $error("held low main line not recognised");
   a_timer_gate: assert property (
      (cpu_out.irq_req && cpu_out.vector == VEC_TIMER) |-> $past(|(tmr_flags & st_q.tmr_en)))
      else $error("timer request without enabled flag");
   a_alarm_holds: assert property (evt.alarm_equal |=> st_q.rtc_flag[RTC_ALRM])
      else $error("alarm flag not held during equality");
   a_stop_clocks: assert property (
      (st_q.lp == LP_STOP) |-> (!cpu_out.proc_clk_en && cpu_out.osc_en == !st_q.stop_osc))
      else $error("stop clock gating wrong");
   a_wait_clocks: assert property ((st_q.lp == LP_WAIT) |-> (!cpu_out.proc_clk_en && cpu_out.osc_en))
      else $error("wait clock gating wrong");

endmodule

// file: design/mcuiw_pkg.sv
// constants, register map and carrier types of the interrupt and wake logic
package mcuiw_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_TCR      = 8'h12;
   localparam logic [7:0] IDX_TSR      = 8'h13;
   localparam logic [7:0] IDX_CAP_LO   = 8'h15;
   localparam logic [7:0] IDX_CMP_LO   = 8'h17;
   localparam logic [7:0] IDX_CNT_LO   = 8'h19;
   localparam logic [7:0] IDX_RTC_STAT = 8'h1C;
   localparam logic [7:0] IDX_RTC_CTRL = 8'h1D;
   localparam logic [7:0] IDX_PIN_EN   = 8'h25;
   localparam logic [7:0] IDX_PIN_FLAG = 8'h26;
   localparam logic [7:0] IDX_MISC     = 8'h27;
   localparam logic [7:0] IDX_LP_CTRL  = 8'h30;
   localparam int         IDX_MSB      = 9;
   localparam int         IDX_LSB      = 2;

   // source indices
   localparam int PIN_MAIN = 0;
   localparam int PIN_A    = 1;
   localparam int PIN_B    = 2;
   localparam int TMR_WRAP = 0;
   localparam int TMR_CMP  = 1;
   localparam int TMR_CAP  = 2;
   localparam int RTC_ALRM = 0;
   localparam int RTC_SEC  = 1;
   localparam int RTC_DAY  = 2;

   // field positions
   localparam int BIT_CAP     = 7;
   localparam int BIT_CMP     = 6;
   localparam int BIT_WRAP    = 5;
   localparam int BIT_B_HI    = 7;
   localparam int BIT_A_HI    = 6;
   localparam int BIT_MAIN_SEL = 5;
   localparam int BIT_B_LVL   = 1;
   localparam int BIT_A_LVL   = 0;
   localparam int BIT_DAY     = 2;
   localparam int BIT_SEC     = 1;
   localparam int BIT_ALRM    = 0;
   localparam int BIT_STOPOSC = 0;

   // vector addresses (low byte of each pair)
   localparam logic [15:0] VEC_RESET = 16'h3FFE;
   localparam logic [15:0] VEC_SWI   = 16'h3FFC;
   localparam logic [15:0] VEC_IRQ   = 16'h3FFA;
   localparam logic [15:0] VEC_AUX_A = 16'h3FF8;
   localparam logic [15:0] VEC_TIMER = 16'h3FF6;
   localparam logic [15:0] VEC_AUX_B = 16'h3FF4;
   localparam logic [15:0] VEC_RTC   = 16'h3FF2;

   localparam logic [2:0]  PINS_IDLE = 3'h7;
   localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

   typedef enum logic [1:0] {
      LP_RUN  = 2'b00,
      LP_WAIT = 2'b01,
      LP_STOP = 2'b10
   } mcuiw_lp_type;

   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } mcuiw_ahb_req_type;

   typedef struct packed {
      logic        hreadyout;
      logic [31:0] hrdata;
      logic        hresp;
   } mcuiw_ahb_rsp_type;

   typedef struct packed {
      logic mask;
      logic swi_exec;
      logic stop_exec;
      logic wait_exec;
      logic ack;
   } mcuiw_cpu_in_type;

   typedef struct packed {
      logic        irq_req;
      logic [15:0] vector;
      logic        stack_push;
      logic        mask_set;
      logic        proc_clk_en;
      logic        osc_en;
   } mcuiw_cpu_out_type;

   typedef struct packed {
      logic wrap;
      logic compare;
      logic capture;
      logic day_roll;
      logic second;
      logic alarm_equal;
      logic spi_irq;
   } mcuiw_evt_type;

endpackage

// file: design/mcuiw_sync.sv
// two-flop synchroniser for the active-low request pins
`timescale 1ns/1ns
module mcuiw_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // pins and synced levels
   input  wire logic [WIDTH-1:0] pin_async,
   output logic      [WIDTH-1:0] pin_sync
);
   import mcuiw_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } mcuiw_sync_state_type;

   mcuiw_sync_state_type st_q;
   mcuiw_sync_state_type st_d;

   always_comb begin
      st_d.meta = pin_async;
      st_d.sync = st_q.meta;
   end

   // idle lines are high, so reset to that level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '1;
      end else begin
         st_q <= st_d;
      end
   end

   assign pin_sync = st_q.sync;

endmodule

// file: design/mcuiw_timer_flags.sv
// timer flags; no reset, the flags survive a device reset
`timescale 1ns/1ns
module mcuiw_timer_flags (
   // clock and reset (reset only quiets the checks)
   input  wire logic       clk,
   input  wire logic       rst,
   // set events and clear strobes
   input  wire logic [2:0] flag_set,
   input  wire logic [2:0] flag_clr,
   // flags
   output logic      [2:0] flags
);
   import mcuiw_pkg::*;

   typedef struct packed {
      logic [2:0] flag;
   } mcuiw_tflag_state_type;

   mcuiw_tflag_state_type st_q;
   mcuiw_tflag_state_type st_d;

   // set wins over a clear in the same cycle
   always_comb begin
      st_d.flag = (st_q.flag & ~flag_clr) | flag_set;
   end

   always_ff @(posedge clk) begin
      st_q <= st_d;
   end

   assign flags = st_q.flag;

   a_tflag_set_sticks: assert property (@(posedge clk) disable iff (rst)
      flag_set[TMR_WRAP] |=> flags[TMR_WRAP])
      else $error("wrap flag not set after event");
   a_tflag_clear_hits: assert property (@(posedge clk) disable iff (rst)
      (flag_clr[TMR_CMP] && !flag_set[TMR_CMP]) |=> !flags[TMR_CMP])
      else $error("compare flag not cleared");

endmodule

// file: testbench/mcuiw_pin_src.sv
// external sources on the active-low request pins
`timescale 1ns/1ns
module mcuiw_pin_src #(
   parameter int SVC = 8
) (
   // clock
   input  wire logic       clk,
   // request lines, idle high
   output logic      [2:0] pins_n
);
   import mcuiw_pkg::*;
   int cyc = 0;
   int last [3] = '{-99, -99, -99};
   initial pins_n = PINS_IDLE;
   always @(posedge clk) cyc <= cyc + 1;
   // a new fall waits until the previous one could have been served
   task drive(input int idx, input logic lvl);
      if (!lvl)
         while (cyc - last[idx] < SVC + 21) @(posedge clk);
      @(posedge clk);
      pins_n[idx] <= lvl;
      if (!lvl) last[idx] = cyc;
   endtask
   task pulse(input int idx, input int w);
      drive(idx, 1'b0);
      repeat (w) @(posedge clk);
      pins_n[idx] <= 1'b1;
   endtask
endmodule

// file: testbench/mcuiw_core_bench.sv
// self-checking bench of the interrupt and wake logic
`timescale 1ns/1ns
module mcuiw_core_bench;
   import mcuiw_pkg::*;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   mcuiw_ahb_req_type bq;
   mcuiw_ahb_req_type bw;
   mcuiw_ahb_rsp_type rsp;
   logic [2:0]        pins_n;
   mcuiw_evt_type     evt;
   mcuiw_cpu_in_type  cpu;
   mcuiw_cpu_out_type co;
   int                n_fail = 0;
   int                checks_done = 0;
   int                pend [7] = '{default: 0};
   logic [31:0]       rd;
   logic [15:0]       vt [7] = '{VEC_RESET, VEC_SWI, VEC_IRQ, VEC_AUX_A, VEC_TIMER, VEC_AUX_B, VEC_RTC};
   logic [7:0]        ri [8] = '{IDX_TCR, IDX_PIN_EN, IDX_PIN_FLAG, IDX_MISC, IDX_RTC_CTRL, IDX_RTC_STAT,
                                 IDX_LP_CTRL, 8'h3F};
   logic [7:0]        rv [8] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   always #2 clk = ~clk;
   always_comb begin
      bw = bq;
      bw.hready = rsp.hreadyout;
   end

   mcuiw_pin_src src (.clk(clk), .pins_n(pins_n));
   mcuiw_core dut (.clk(clk), .rst(rst), .ahb_req(bw), .ahb_rsp(rsp), .req_pins_n(pins_n), .evt(evt),
                   .cpu_in(cpu), .cpu_out(co));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // no cycle count assumed: only the watchdog ends a stuck wait
   task automatic rdy();
      do begin
         @(posedge clk);
      end while (rsp.hreadyout !== 1'b1);
   endtask

   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clk);
      bq.hsel <= 1'b1;
      bq.haddr <= {22'h0, idx, 2'b00};
      bq.htrans <= 2'b10;
      bq.hwrite <= wr;
      bq.hsize <= 3'h2;
      rdy();
      bq.hsel <= 1'b0;
      bq.htrans <= 2'b00;
      bq.hwdata <= {24'h0, wd};
      rdy();
      rd = rsp.hrdata;
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [31:0] msk, input logic [31:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(rd & msk, exp);
      chk(rsp.hresp, 1'b0);
   endtask

   // model of the request line: lowest pending index wins, swi ignores mask
   // four edges cover two sync flops, the flag and the request; mask read after they pass
   task automatic rq();
      logic [16:0] e;
      e = 17'h0;
      repeat (4) @(posedge clk);
      for (int i = 6; i > 0; i--)
         if (pend[i] != 0 && (i == 1 || cpu.mask == 1'b0)) e = {1'b1, vt[i]};
      @(negedge clk);
      chk(co.irq_req, e[16]);
      if (e[16]) chk(co.vector, e[15:0]);
   endtask

   // one-cycle pulse on a cpu strobe: 0 ack, 1 wait, 2 stop, 3 swi
   task automatic cp(input int k);
      @(posedge clk) cpu <= mcuiw_cpu_in_type'(cpu | (5'h01 << k));
      @(posedge clk) cpu <= mcuiw_cpu_in_type'(cpu & ~(5'h01 << k));
   endtask

   task automatic ev(input int k);
      @(posedge clk) evt <= mcuiw_evt_type'(evt | (7'h40 >> k));
      @(posedge clk) evt <= mcuiw_evt_type'(evt & ~(7'h40 >> k));
   endtask

   task automatic ack(input int s);
      cp(0);
      @(negedge clk);
      chk(co.irq_req, 1'b0);
      chk(co.mask_set, 1'b1);
      chk(co.stack_push, s != 0);
      if (s < 3) pend[s] = 0;
   endtask

   task automatic wake();
      int n;
      n = 0;
      while (co.proc_clk_en !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk(co.proc_clk_en, 1'b1);
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      logic [7:0] v;
      bq = '0;
      evt = '0;
      cpu = '0;
      cpu.mask = 1'b1;
      void'($urandom(87));
      @(posedge clk);
      @(negedge clk);
      chk(co.vector, VEC_RESET);
      chk(co.mask_set, 1'b1);
      @(posedge clk) rst <= 1'b0;
      ack(0);
      foreach (ri[i]) rchk(ri[i], 32'hFFFF_FFFF, {24'h0, rv[i]});
      repeat (4) begin
         v = 8'($urandom);
         bus(1'b1, IDX_MISC, v);
         rchk(IDX_MISC, 32'hE0, {24'h0, v & 8'hE0});
         bus(1'b1, IDX_PIN_EN, v);
         rchk(IDX_PIN_EN, 32'hC0, {24'h0, v & 8'hC0});
      end
      bus(1'b1, 8'h3F, 8'hFF);
      rchk(8'h3F, 32'hFFFF_FFFF, 32'h0);
      $display("test registers done");
      bus(1'b1, IDX_MISC, 8'hE0);
      bus(1'b1, IDX_PIN_EN, 8'hC0);
      @(posedge clk) cpu.mask <= 1'b0;
      src.drive(1, 1'b0);
      pend[3] = 1;
      rq();
      rchk(IDX_PIN_FLAG, 32'hFF, 32'h42);
      ack(3);
      @(posedge clk) cpu.mask <= 1'b1;
      rq();
      bus(1'b1, IDX_PIN_FLAG, 8'h40);
      pend[3] = 0;
      // line still low, edge-only: cleared flag must stay clear
      rchk(IDX_PIN_FLAG, 32'hFF, 32'h02);
      src.drive(1, 1'b1);
      bus(1'b1, IDX_PIN_EN, 8'h40);
      @(posedge clk) cpu.mask <= 1'b0;
      src.pulse(2, 2 + $urandom % 4);
      rq();
      rchk(IDX_PIN_FLAG, 32'hFF, 32'h83);
      bus(1'b1, IDX_PIN_EN, 8'hC0);
      pend[5] = 1;
      rq();
      bus(1'b1, IDX_PIN_FLAG, 8'h80);
      pend[5] = 0;
      rq();
      $display("test aux pins done");
      @(posedge clk) cpu.mask <= 1'b1;
      cp(3);
      pend[1] = 1;
      rq();
      ack(1);
      bus(1'b1, IDX_MISC, 8'h00);
      src.drive(0, 1'b0);
      src.drive(1, 1'b0);
      pend[2] = 1;
      pend[3] = 1;
      @(posedge clk) cpu.mask <= 1'b0;
      rq();
      ack(2);
      pend[2] = 1;
      rq();
      bus(1'b1, IDX_MISC, 8'hA0);
      ack(2);
      rq();
      src.drive(0, 1'b1);
      src.drive(1, 1'b1);
      bus(1'b1, IDX_PIN_FLAG, 8'h40);
      pend[3] = 0;
      rq();
      $display("test priority done");
      ev(0);
      ev(1);
      ev(2);
      rchk(IDX_TSR, 32'hE0, 32'hE0);
      rq();
      bus(1'b1, IDX_TCR, 8'h20);
      pend[4] = 1;
      rq();
      bus(1'b0, IDX_TSR, 8'h00);
      bus(1'b0, IDX_CNT_LO, 8'h00);
      pend[4] = 0;
      rchk(IDX_TSR, 32'hE0, 32'hC0);
      bus(1'b1, IDX_CMP_LO, 8'h00);
      rchk(IDX_TSR, 32'hE0, 32'h80);
      bus(1'b0, IDX_CAP_LO, 8'h00);
      rchk(IDX_TSR, 32'hE0, 32'h00);
      rq();
      $display("test timer done");
      bus(1'b1, IDX_RTC_CTRL, 8'h04);
      ev(3);
      ev(4);
      pend[6] = 1;
      rq();
      rchk(IDX_RTC_STAT, 32'h07, 32'h06);
      bus(1'b1, IDX_RTC_STAT, 8'h06);
      pend[6] = 0;
      rq();
      @(posedge clk) evt.alarm_equal <= 1'b1;
      bus(1'b1, IDX_RTC_STAT, 8'h01);
      rchk(IDX_RTC_STAT, 32'h07, 32'h01);
      @(posedge clk) evt.alarm_equal <= 1'b0;
      bus(1'b1, IDX_RTC_STAT, 8'h01);
      rchk(IDX_RTC_STAT, 32'h07, 32'h00);
      $display("test clock calendar done");
      cp(1);
      @(negedge clk);
      chk(co.proc_clk_en, 1'b0);
      chk(co.osc_en, 1'b1);
      @(posedge clk) evt.spi_irq <= 1'b1;
      wake();
      @(posedge clk) evt.spi_irq <= 1'b0;
      for (int o = 0; o < 2; o++) begin
         bus(1'b1, IDX_LP_CTRL, 8'(o));
         cp(2);
         @(negedge clk);
         chk(co.osc_en, o == 0);
         src.pulse(2, 3);
         wake();
         chk(co.osc_en, 1'b1);
      end
      bus(1'b1, IDX_PIN_FLAG, 8'h80);
      $display("test low power done");
      ev(0);
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      @(posedge clk) rst <= 1'b0;
      ack(0);
      rchk(IDX_TSR, 32'h20, 32'h20);
      $display("test second reset done");
      end_sim();
   end

   // the sequence needs a few hundred cycles
   initial begin
      #80000;
      n_fail++;
      end_sim();
   end
endmodule
